// ### src/sideband_pkg.sv
// Package: state encodings and timing constants of the sideband power control block
package sideband_pkg;

    // ----------------------------------------
    // Operating states, one-hot
    // ----------------------------------------
    typedef enum logic [6:0] {
        ST_RUN        = 7'h01,
        ST_MGMT_ACK   = 7'h02,
        ST_MGMT       = 7'h04,
        ST_GRANT_ACK  = 7'h08,
        ST_GRANT      = 7'h10,
        ST_SLEEP      = 7'h20,
        ST_TRIP       = 7'h40
    } pwr_state_t;

    // ----------------------------------------
    // Timing and widths
    // ----------------------------------------
    localparam int unsigned CORE_CLK_MHZ = 125;
    // Cycles the state save takes before the acknowledge goes out
    localparam int unsigned SAVE_CYCLES_DEF = 4;
    localparam int unsigned SAVE_CNT_W = 4;
    // Trip threshold in degrees C
    localparam logic [7:0] TRIP_TEMP_C = 8'h7D;
    // Acknowledge codes placed on the front bus request
    localparam logic [1:0] ACK_MGMT = 2'h1;
    localparam logic [1:0] ACK_GRANT = 2'h2;
    localparam logic [1:0] ACK_NONE = 2'h0;

endpackage

// ### src/sideband_power_ctrl.sv
// Sideband power and management-mode control of the processor core
//
// Operation
// - On accepting a management request, save state and enter management mode.
// - After accepting it, issue a management acknowledge transaction on the front bus.
// - In management mode, fetch and execute from the management handler.
// - Management request held while reset releases floats every output.
// - Stop-clock assertion enters grant state and issues a grant acknowledge.
// - In grant, gate core clocks; bus unit and local_irq_ctrl stay clocked.
// - In grant, keep snooping bus transactions and servicing interrupts.
// - Stop-clock release restarts all clocks and resumes execution.
// - Stop-clock never affects the bus clock and is taken asynchronously.
// - Halt all execution when the junction exceeds the trip threshold.
// - Report a thermal halt on the dedicated overheat trip output.
// - Sleep request in grant moves to sleep; only clock generator runs.
// - In sleep, react only to reset, sleep release and over-temperature trip; ignore snoops, interrupts.
// - Sleep release returns to grant, restarting bus and local_irq_ctrl clocks; core clocks stay gated.
module sideband_power_ctrl
    import sideband_pkg::*;
#(
    parameter int unsigned SAVE_CYCLES = SAVE_CYCLES_DEF
) (
    input  wire logic       i_core_clk,        // Core clock, 125 MHz
    input  wire logic       i_reset,           // Synchronous reset, active high
    input  wire logic       i_clk_en,          // Freezes all state while low
    input  wire logic       i_mgmt_irq_n,      // Async management request, low
    input  wire logic       i_stop_clk_req_n,  // Async stop-clock request, low
    input  wire logic       i_sleep_req_n,     // Async sleep request, low
    input  wire logic [7:0] i_junction_temp,   // Sensor reading, degrees C
    input  wire logic       i_ack_done,        // Front bus took the acknowledge
    output logic            o_ack_valid,       // Acknowledge transaction request
    output logic [1:0]      o_ack_code,        // Acknowledge type
    output logic            o_state_save,      // Save execution state
    output logic            o_system_mgmt_mode, // Core in management mode
    output logic            o_fetch_handler,   // Fetch from management handler
    output logic            o_core_clk_en,     // Core units clock gate
    output logic            o_bus_clk_en,      // Bus unit clock gate
    output logic            o_irq_clk_en,      // local_irq_ctrl clock gate
    output logic            o_snoop_en,        // Snoops and interrupts accepted
    output logic            o_exec_en,         // Instruction execution allowed
    output logic            o_overheat_trip_n, // Thermal trip, active low
    output logic            o_outputs_float    // All pins to high impedance
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    // Three stages; a change counts once stages two and three agree, which
    // rejects a level that has only just settled out of metastability.
    logic [2:0] mgmt_sync, next_mgmt_sync;
    logic [2:0] stop_sync, next_stop_sync;
    logic [2:0] sleep_sync, next_sleep_sync;
    logic mgmt_req, next_mgmt_req;
    logic stop_req, next_stop_req;
    logic sleep_req, next_sleep_req;
    logic mgmt_req_d, next_mgmt_req_d;
    logic mgmt_edge;

    // A held request level is one request, not one per cycle
    assign mgmt_edge = mgmt_req & ~mgmt_req_d;

    always_comb begin
        next_mgmt_req_d = mgmt_req;
        next_mgmt_sync = {mgmt_sync[1:0], ~i_mgmt_irq_n};
        next_stop_sync = {stop_sync[1:0], ~i_stop_clk_req_n};
        next_sleep_sync = {sleep_sync[1:0], ~i_sleep_req_n};
        next_mgmt_req = mgmt_req;
        next_stop_req = stop_req;
        next_sleep_req = sleep_req;
        if (mgmt_sync[2] == mgmt_sync[1]) begin
            next_mgmt_req = mgmt_sync[2];
        end
        if (stop_sync[2] == stop_sync[1]) begin
            next_stop_req = stop_sync[2];
        end
        if (sleep_sync[2] == sleep_sync[1]) begin
            next_sleep_req = sleep_sync[2];
        end
    end

    // No reset here: the chain keeps sampling through reset, so a request
    // held across reset release is already settled on the first free edge
    always_ff @(posedge i_core_clk) begin
        if (i_clk_en) begin
            mgmt_sync <= next_mgmt_sync;
            stop_sync <= next_stop_sync;
            sleep_sync <= next_sleep_sync;
            mgmt_req <= next_mgmt_req;
            stop_req <= next_stop_req;
            sleep_req <= next_sleep_req;
            mgmt_req_d <= next_mgmt_req_d;
        end
    end

    // ----------------------------------------
    // Reset-release strap: float outputs
    // ----------------------------------------
    // Sampled on the first clocked edge after reset drops; sticky until the
    // next reset because the pins stay floated for board test.
    logic in_reset_d, next_in_reset_d;
    logic float_out, next_float_out;

    always_comb begin
        next_in_reset_d = 1'b0;
        next_float_out = float_out;
        if (in_reset_d && mgmt_req) begin
            next_float_out = 1'b1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            in_reset_d <= 1'b1;
            float_out <= 1'b0;
        end else if (i_clk_en) begin
            in_reset_d <= next_in_reset_d;
            float_out <= next_float_out;
        end
    end

    // ----------------------------------------
    // Power state machine
    // ----------------------------------------
    pwr_state_t state, next_state;
    logic [SAVE_CNT_W-1:0] save_cnt, next_save_cnt;
    logic mgmt_pend, next_mgmt_pend;
    logic over_temp;

    assign over_temp = (i_junction_temp > TRIP_TEMP_C);

    always_comb begin
        next_state = state;
        next_save_cnt = save_cnt;
        // Request held sticky so a pulse during grant is not lost
        next_mgmt_pend = mgmt_pend | mgmt_edge;
        if (over_temp) begin
            next_state = ST_TRIP;
        end else begin
            case (state)
                ST_RUN: begin
                    if (mgmt_pend) begin
                        next_state = ST_MGMT_ACK;
                        // A fresh edge in the same cycle wins over the clear
                        next_mgmt_pend = mgmt_edge;
                        next_save_cnt = SAVE_CNT_W'(SAVE_CYCLES);
                    end else if (stop_req) begin
                        next_state = ST_GRANT_ACK;
                    end
                end
                ST_MGMT_ACK: begin
                    if (save_cnt != '0) begin
                        next_save_cnt = save_cnt - SAVE_CNT_W'(1);
                    end else if (i_ack_done) begin
                        next_state = ST_MGMT;
                    end
                end
                ST_MGMT: begin
                    // No path back to run from here; only a stop request
                    // (or a trip) leaves, taking the clocks down
                    if (stop_req) begin
                        next_state = ST_GRANT_ACK;
                    end
                end
                ST_GRANT_ACK: begin
                    if (i_ack_done) begin
                        next_state = ST_GRANT;
                    end
                end
                ST_GRANT: begin
                    if (sleep_req) begin
                        next_state = ST_SLEEP;
                    end else if (!stop_req) begin
                        next_state = ST_RUN;
                    end
                end
                ST_SLEEP: begin
                    if (!sleep_req) begin
                        next_state = ST_GRANT;
                    end
                    next_mgmt_pend = mgmt_pend;
                end
                ST_TRIP: begin
                    next_state = ST_TRIP;
                end
                default: begin
                    next_state = ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state <= ST_RUN;
            save_cnt <= '0;
            mgmt_pend <= 1'b0;
        end else if (i_clk_en) begin
            state <= next_state;
            save_cnt <= next_save_cnt;
            mgmt_pend <= next_mgmt_pend;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    logic next_ack_valid;
    logic [1:0] next_ack_code;
    logic next_state_save;
    logic next_mgmt_mode;
    logic next_fetch_handler;
    logic next_core_clk_en;
    logic next_bus_clk_en;
    logic next_irq_clk_en;
    logic next_snoop_en;
    logic next_exec_en;
    logic next_trip_n;
    logic mgmt_mode_hold;

    // Management mode persists through grant and sleep until reset
    assign mgmt_mode_hold = o_system_mgmt_mode | (next_state == ST_MGMT);

    always_comb begin
        next_ack_valid = 1'b0;
        next_ack_code = ACK_NONE;
        next_state_save = 1'b0;
        next_mgmt_mode = mgmt_mode_hold;
        next_fetch_handler = 1'b0;
        next_core_clk_en = 1'b1;
        next_bus_clk_en = 1'b1;
        next_irq_clk_en = 1'b1;
        next_snoop_en = 1'b1;
        next_exec_en = 1'b1;
        next_trip_n = 1'b1;
        case (next_state)
            ST_MGMT_ACK: begin
                next_exec_en = 1'b0;
                next_state_save = (next_save_cnt != '0);
                next_ack_valid = (next_save_cnt == '0);
                next_ack_code = (next_save_cnt == '0) ? ACK_MGMT : ACK_NONE;
            end
            ST_MGMT: begin
                next_fetch_handler = 1'b1;
            end
            ST_GRANT_ACK: begin
                next_exec_en = 1'b0;
                next_ack_valid = 1'b1;
                next_ack_code = ACK_GRANT;
            end
            ST_GRANT: begin
                next_core_clk_en = 1'b0;
                next_exec_en = 1'b0;
                next_snoop_en = 1'b1;
            end
            ST_SLEEP: begin
                // Only the clock generator keeps running here
                next_core_clk_en = 1'b0;
                next_bus_clk_en = 1'b0;
                next_irq_clk_en = 1'b0;
                next_snoop_en = 1'b0;
                next_exec_en = 1'b0;
            end
            ST_TRIP: begin
                next_exec_en = 1'b0;
                next_core_clk_en = 1'b0;
                next_snoop_en = 1'b0;
                next_trip_n = 1'b0;
            end
            default: begin
                next_exec_en = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_ack_valid <= 1'b0;
            o_ack_code <= ACK_NONE;
            o_state_save <= 1'b0;
            o_system_mgmt_mode <= 1'b0;
            o_fetch_handler <= 1'b0;
            o_core_clk_en <= 1'b1;
            o_bus_clk_en <= 1'b1;
            o_irq_clk_en <= 1'b1;
            o_snoop_en <= 1'b1;
            o_exec_en <= 1'b0;
            o_overheat_trip_n <= 1'b1;
            o_outputs_float <= 1'b0;
        end else if (i_clk_en) begin
            o_ack_valid <= next_ack_valid;
            o_ack_code <= next_ack_code;
            o_state_save <= next_state_save;
            o_system_mgmt_mode <= next_mgmt_mode;
            o_fetch_handler <= next_fetch_handler;
            o_core_clk_en <= next_core_clk_en;
            o_bus_clk_en <= next_bus_clk_en;
            o_irq_clk_en <= next_irq_clk_en;
            o_snoop_en <= next_snoop_en;
            o_exec_en <= next_exec_en;
            o_overheat_trip_n <= next_trip_n;
            o_outputs_float <= next_float_out;
        end
    end

endmodule

// ### test/sideband_assertions.sv
// Checker: port-level timing relations of the sideband power control block
module sideband_assertions
    import sideband_pkg::*;
#(
    parameter int unsigned SAVE_CYCLES = SAVE_CYCLES_DEF
) (
    input wire logic i_core_clk, // Clock
    input wire logic i_reset, // Sync reset
    input wire logic i_clk_en, // Global enable
    input wire logic i_mgmt_irq_n, // Mgmt request
    input wire logic i_stop_clk_req_n, // Stop request
    input wire logic i_sleep_req_n, // Sleep request
    input wire logic [7:0] i_junction_temp, // Temperature
    input wire logic i_ack_done, // Ack taken
    input wire logic o_ack_valid, // Ack request
    input wire logic [1:0] o_ack_code, // Ack type
    input wire logic o_state_save, // Saving
    input wire logic o_system_mgmt_mode, // Mgmt mode
    input wire logic o_fetch_handler, // Handler fetch
    input wire logic o_core_clk_en, // Core gate
    input wire logic o_bus_clk_en, // Bus gate
    input wire logic o_irq_clk_en, // Irq gate
    input wire logic o_snoop_en, // Snoop on
    input wire logic o_exec_en, // Exec on
    input wire logic o_overheat_trip_n, // Trip, low
    input wire logic o_outputs_float // Float strap
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    // Enabled edges seen with save high; frozen edges must not stretch the count
    logic [7:0] save_cnt;
    logic [7:0] next_save_cnt;
    always_comb begin
        next_save_cnt = save_cnt;
        if (i_clk_en) begin
            next_save_cnt = o_state_save ? save_cnt + 8'h01 : 8'h00;
        end
    end
    always_ff @(posedge i_core_clk) begin
        save_cnt <= i_reset ? 8'h00 : next_save_cnt;
    end

    save_len_a: assert property ($fell(o_state_save) |-> save_cnt == 8'(SAVE_CYCLES))
        else $error("state save length wrong");
    ack_held_a: assert property (o_ack_valid && !i_ack_done && i_clk_en
        && i_junction_temp <= TRIP_TEMP_C |=> o_ack_valid) else $error("ack dropped early");
    fetch_mode_a: assert property (o_fetch_handler |-> o_system_mgmt_mode)
        else $error("handler fetch outside mgmt mode");
    grant_gate_a: assert property (o_ack_valid && o_ack_code == ACK_GRANT && i_ack_done
        && i_clk_en |-> ##[1:3] (!o_core_clk_en && o_bus_clk_en && o_irq_clk_en && o_snoop_en))
        else $error("grant clock gating wrong");
    resume_a: assert property ($rose(i_stop_clk_req_n) && !o_core_clk_en && o_bus_clk_en
        && o_overheat_trip_n && i_sleep_req_n && i_clk_en |-> ##[2:10] (o_core_clk_en && o_exec_en))
        else $error("no resume after stop release");
    sleep_quiet_a: assert property (!o_bus_clk_en && o_overheat_trip_n
        |-> !o_core_clk_en && !o_irq_clk_en && !o_snoop_en) else $error("sleep not quiet");
    trip_halt_a: assert property (i_junction_temp > TRIP_TEMP_C && i_clk_en
        |-> ##[1:3] (!o_overheat_trip_n && !o_exec_en)) else $error("no halt on overheat");
    trip_sticky_a: assert property (!o_overheat_trip_n
        |=> !o_overheat_trip_n && !o_exec_en && !o_core_clk_en) else $error("trip released");
    sync_delay_a: assert property (($fell(i_mgmt_irq_n) || $fell(i_stop_clk_req_n))
        && o_exec_en && i_clk_en |-> o_exec_en [*2]) else $error("request acted unsynchronised");

    float_hold_a: assert property (o_outputs_float |=> o_outputs_float)
        else $error("float strap released");

    cover property ($rose(o_fetch_handler));
    cover property ($fell(o_bus_clk_en));
    cover property ($fell(o_overheat_trip_n));
endmodule

bind sideband_power_ctrl sideband_assertions #(.SAVE_CYCLES(SAVE_CYCLES)) i_sideband_assertions (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_mgmt_irq_n(i_mgmt_irq_n), .i_stop_clk_req_n(i_stop_clk_req_n),
    .i_sleep_req_n(i_sleep_req_n), .i_junction_temp(i_junction_temp), .i_ack_done(i_ack_done),
    .o_ack_valid(o_ack_valid), .o_ack_code(o_ack_code), .o_state_save(o_state_save),
    .o_system_mgmt_mode(o_system_mgmt_mode), .o_fetch_handler(o_fetch_handler),
    .o_core_clk_en(o_core_clk_en), .o_bus_clk_en(o_bus_clk_en), .o_irq_clk_en(o_irq_clk_en),
    .o_snoop_en(o_snoop_en), .o_exec_en(o_exec_en), .o_overheat_trip_n(o_overheat_trip_n),
    .o_outputs_float(o_outputs_float));

// ### test/system_logic_model.sv
// Partner: system logic taking acknowledge transactions off the front bus
module system_logic_model (
    input wire logic i_core_clk, // Clock
    input wire logic i_reset, // Sync reset
    input wire logic i_ack_valid, // Ack request seen
    input wire logic [2:0] i_delay, // Answer delay, cycles
    output logic o_ack_done // Ack taken, one cycle
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_cnt;
    logic busy;
    // One answer per request; busy blocks a second answer before the request drops
    always @(posedge i_core_clk) begin
        o_ack_done <= 1'b0;
        if (i_reset || !i_ack_valid) begin
            busy <= 1'b0;
            wait_cnt <= 3'h0;
        end else if (!busy && wait_cnt == i_delay) begin
            o_ack_done <= 1'b1;
            busy <= 1'b1;
        end else if (!busy) begin
            wait_cnt <= wait_cnt + 3'h1;
        end
    end
endmodule

// ### test/testbench.sv
// Testbench: sideband power control block against the system logic model
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sideband_pkg::*;

    localparam int unsigned SAVE = 2; // Short state save keeps the run brief
    localparam int ACK = 0, SV = 1, FETCH = 3, CORE = 4, BUS = 5, EXEC = 6, TRIP = 7;
    logic i_core_clk = 0, i_reset = 1, i_clk_en = 1, i_ack_done;
    logic i_mgmt_irq_n = 1, i_stop_clk_req_n = 1, i_sleep_req_n = 1;
    logic [7:0] i_junction_temp = 8'h00, seed = 8'h5D;
    logic [2:0] ack_delay = 3'h0;
    logic [1:0] o_ack_code;
    logic o_ack_valid, o_state_save, o_system_mgmt_mode, o_fetch_handler, o_core_clk_en;
    logic o_bus_clk_en, o_irq_clk_en, o_snoop_en, o_exec_en, o_overheat_trip_n, o_outputs_float;
    int num_errors = 0, checks_done = 0, cycles = 0, n, k;
    wire [7:0] outs = {o_overheat_trip_n, o_exec_en, o_bus_clk_en, o_core_clk_en,
        o_fetch_handler, o_system_mgmt_mode, o_state_save, o_ack_valid};

    sideband_power_ctrl #(.SAVE_CYCLES(SAVE)) i_sideband_power_ctrl (
        .i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
        .i_mgmt_irq_n(i_mgmt_irq_n), .i_stop_clk_req_n(i_stop_clk_req_n),
        .i_sleep_req_n(i_sleep_req_n), .i_junction_temp(i_junction_temp),
        .i_ack_done(i_ack_done), .o_ack_valid(o_ack_valid), .o_ack_code(o_ack_code),
        .o_state_save(o_state_save), .o_system_mgmt_mode(o_system_mgmt_mode),
        .o_fetch_handler(o_fetch_handler), .o_core_clk_en(o_core_clk_en),
        .o_bus_clk_en(o_bus_clk_en), .o_irq_clk_en(o_irq_clk_en), .o_snoop_en(o_snoop_en),
        .o_exec_en(o_exec_en), .o_overheat_trip_n(o_overheat_trip_n),
        .o_outputs_float(o_outputs_float));
    system_logic_model i_system_logic_model (.i_core_clk(i_core_clk), .i_reset(i_reset),
        .i_ack_valid(o_ack_valid), .i_delay(ack_delay), .o_ack_done(i_ack_done));

    // Clock at 125 MHz
    initial forever #4 i_core_clk = ~i_core_clk;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Expected trip pin for a temperature; the threshold itself must not trip
    function automatic logic trip_expect(logic [7:0] t);
        return !(t > TRIP_TEMP_C);
    endfunction
    task automatic check(string name, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
            num_errors++;
        end
    endtask
    // Bounded wait on settled outputs, so a hang shows as a mismatch
    task automatic wait_for(int b, logic v, string name);
        for (n = 0; n < 40 && outs[b] !== v; n++) @(negedge i_core_clk);
        check(name, v, outs[b]);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Ceiling far above the few hundred cycles the sequence needs
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge i_core_clk);
        i_reset <= 1'b0;
        repeat (3) @(negedge i_core_clk);
        check("run after reset", 8'h03, {o_exec_en, o_overheat_trip_n});
        check("no float", 8'h00, o_outputs_float);
        // Frozen enable: a request pulse must not pass the synchroniser
        @(posedge i_core_clk);
        i_clk_en <= 1'b0;
        i_stop_clk_req_n <= 1'b0;
        repeat (10) @(posedge i_core_clk);
        i_stop_clk_req_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        i_clk_en <= 1'b1;
        repeat (12) @(negedge i_core_clk);
        check("frozen request", 8'h00, o_ack_valid);
        $display("test freeze done");
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            @(posedge i_core_clk);
            ack_delay <= seed[2:0];
            i_junction_temp <= seed % 8'h7E;
            i_mgmt_irq_n <= 1'b0;
            wait_for(SV, 1'b1, "save start");
            for (k = 0; k < 40 && o_state_save === 1'b1; k++) @(negedge i_core_clk);
            check("save length", 8'(SAVE), 8'(k));
            wait_for(ACK, 1'b1, "mgmt ack");
            check("mgmt code", ACK_MGMT, o_ack_code);
            wait_for(FETCH, 1'b1, "handler fetch");
            check("mgmt mode", 8'h03, {o_system_mgmt_mode, o_exec_en});
            @(posedge i_core_clk);
            i_stop_clk_req_n <= 1'b0;
            i_mgmt_irq_n <= 1'b1;
            wait_for(ACK, 1'b1, "grant ack");
            check("grant code", ACK_GRANT, o_ack_code);
            wait_for(CORE, 1'b0, "core gated");
            check("grant clocks", 8'h07, {o_bus_clk_en, o_irq_clk_en, o_snoop_en});
            @(posedge i_core_clk);
            i_sleep_req_n <= 1'b0;
            wait_for(BUS, 1'b0, "sleep entry");
            check("sleep quiet", 8'h00, {o_core_clk_en, o_irq_clk_en, o_snoop_en});
            @(posedge i_core_clk);
            i_sleep_req_n <= 1'b1;
            wait_for(BUS, 1'b1, "sleep exit");
            check("back in grant", 8'h00, o_core_clk_en);
            @(posedge i_core_clk);
            i_stop_clk_req_n <= 1'b1;
            wait_for(EXEC, 1'b1, "resume");
            check("core clock back", 8'h01, o_core_clk_en);
            $display("test cycle %0d done", i);
        end
        // Thermal boundary, then trip and stickiness
        @(posedge i_core_clk);
        i_junction_temp <= TRIP_TEMP_C;
        repeat (12) @(negedge i_core_clk);
        check("no trip at limit", trip_expect(TRIP_TEMP_C), o_overheat_trip_n);
        @(posedge i_core_clk);
        i_junction_temp <= TRIP_TEMP_C + 8'h01;
        wait_for(TRIP, trip_expect(TRIP_TEMP_C + 8'h01), "trip pin");
        check("halted", 8'h00, o_exec_en);
        @(posedge i_core_clk);
        i_junction_temp <= 8'h00;
        repeat (10) @(negedge i_core_clk);
        check("trip sticky", 8'h00, o_overheat_trip_n);
        $display("test thermal done");
        @(posedge i_core_clk);
        i_reset <= 1'b1;
        i_mgmt_irq_n <= 1'b0;
        repeat (16) @(posedge i_core_clk);
        i_reset <= 1'b0;
        repeat (3) @(negedge i_core_clk);
        check("float strap", 8'h01, o_outputs_float);
        check("trip cleared", 8'h03, {o_overheat_trip_n, o_exec_en});
        $display("test second reset done");
        summarize();
    end
endmodule
